// File: rtl/lsc_pkg.sv
// Constants, register map and carrier types of the load switch control block
// Functional notes
// R1: High switch follows control bit, gated by pulse
// R2: High open-load flag while current below threshold
// R3: High current-limit flag while in limitation
// R4: High overtemp: switch off, latch, report source
// R5: High thermal shutdown sets both status flags
// R6: Unmasked high overtemp drives interrupt output active
// R7: High re-enable by control write after overtemp
// R8: Overvoltage shutdown enabled turns high switch off
// R9: High re-enable by control write after overvoltage
// R10: High switch may stay on in low power
// R11: Each low switch follows its own bit
// R12: Low switch pulse gating, independent per switch
// R13: Separate open-load flag per low switch
// R14: Separate current-limit flag per low switch
// R15: Low overtemp: both off, latch, report source
// R16: Low thermal shutdown sets all low flags
// R17: Unmasked low overtemp drives interrupt output active
// R18: Masked source: interrupt high, flag not set
// R19: Low re-enable by control write after overtemp
// R20: Overvoltage shutdown enabled turns low switches off
// R21: Low re-enable by control write after overvoltage
// R22: Low switches forced off in low power
// R23: Pulse enable clear: control bit alone drives
// R24: Shut switch stays off until re-enabling write
package lsc_pkg;

   // ==========================================================
   // Register bus geometry
   localparam int unsigned LSC_AW = 4;
   localparam int unsigned LSC_DW = 4;

   // ==========================================================
   // Register offsets
   localparam logic [3:0] LSC_MODE_CONTROL_REG = 4'h0;
   localparam logic [3:0] LSC_HIGH_SWITCH_CONTROL_REG = 4'h6;
   localparam logic [3:0] LSC_HIGH_SWITCH_STATUS_REG = 4'h7;
   localparam logic [3:0] LSC_LOW_SWITCH_CONTROL_REG = 4'h8;
   localparam logic [3:0] LSC_LOW_SWITCH_STATUS_REG = 4'h9;
   localparam logic [3:0] LSC_INTERRUPT_MASK_REG = 4'hE;
   localparam logic [3:0] LSC_INTERRUPT_SOURCE_REG = 4'hF;

   // ==========================================================
   // Field positions
   localparam int unsigned LSC_OV_SHUT_EN_BIT = 3;
   localparam int unsigned LSC_HS_PEN_BIT = 2;
   localparam int unsigned LSC_HS_ON_BIT = 0;
   localparam int unsigned LSC_HS_OL_BIT = 1;
   localparam int unsigned LSC_HS_CL_BIT = 0;
   localparam int unsigned LSC_LSB_PEN_BIT = 3;
   localparam int unsigned LSC_LSA_PEN_BIT = 2;
   localparam int unsigned LSC_LSB_ON_BIT = 1;
   localparam int unsigned LSC_LSA_ON_BIT = 0;
   localparam int unsigned LSC_LSB_OL_BIT = 3;
   localparam int unsigned LSC_LSB_CL_BIT = 2;
   localparam int unsigned LSC_LSA_OL_BIT = 1;
   localparam int unsigned LSC_LSA_CL_BIT = 0;
   localparam int unsigned LSC_HIGH_MASK_BIT = 1;
   localparam int unsigned LSC_LOW_MASK_BIT = 0;

   // ==========================================================
   // Interrupt source codes and fixed read data patterns
   localparam logic [3:0] LSC_SRC_NONE = 4'h0;
   localparam logic [3:0] LSC_SRC_HIGH = 4'h2;
   localparam logic [3:0] LSC_SRC_LOW = 4'h3;
   localparam logic [3:0] LSC_ALL_FLAGS = 4'hF;
   localparam logic [3:0] LSC_ZERO4 = 4'h0;
   localparam logic [1:0] LSC_BOTH2 = 2'h3;

   // ==========================================================
   // Analog condition pins, all asynchronous to the clock
   typedef struct packed {
      logic pulse;
      logic high_voltage;
      logic hs_overtemp;
      logic hs_open_load;
      logic hs_current_limit;
      logic ls_overtemp;
      logic lsa_open_load;
      logic lsa_current_limit;
      logic lsb_open_load;
      logic lsb_current_limit;
   } lsc_pins_s;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [3:0] wdata;
      logic wr;
      logic rd;
   } lsc_req_s;

endpackage

// File: rtl/lsc_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module lsc_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lsc_sync_s;

   lsc_sync_s st;
   lsc_sync_s next_st;

   // First stage feeds only the second stage
   always_comb begin
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.s2;
endmodule
`default_nettype wire

// File: rtl/lsc_top.sv
// Load switch control: one high side and two low side protected switches
`timescale 1ns/1ps
`default_nettype none
module lsc_top
   import lsc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [3:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [3:0] RDATA_O,
   input wire logic LOW_POWER_I,
   input wire logic DIRECT_PULSE_INPUT_I,
   input wire logic HIGH_VOLTAGE_I,
   input wire logic HS_OVERTEMP_I,
   input wire logic HS_OPEN_LOAD_I,
   input wire logic HS_CURRENT_LIMIT_I,
   input wire logic LS_OVERTEMP_I,
   input wire logic LS_A_OPEN_LOAD_I,
   input wire logic LS_A_CURRENT_LIMIT_I,
   input wire logic LS_B_OPEN_LOAD_I,
   input wire logic LS_B_CURRENT_LIMIT_I,
   output logic HIGH_SWITCH_ON_O,
   output logic LOW_SWITCH_A_ON_O,
   output logic LOW_SWITCH_B_ON_O,
   output logic IRQ_N_O
);

   // ==========================================================
   // State
   typedef struct packed {
      logic overvoltage_shutdown_enable;
      logic high_switch_irq_mask;
      logic low_switch_irq_mask;
      logic high_switch_pulse_enable;
      logic high_switch_on;
      logic low_switch_b_pulse_enable;
      logic low_switch_a_pulse_enable;
      logic low_switch_b_on;
      logic low_switch_a_on;
      logic hs_ot_shut;
      logic hs_hv_shut;
      logic ls_ot_shut;
      logic ls_hv_shut;
      logic hs_ot_prev;
      logic ls_ot_prev;
      logic hs_irq;
      logic ls_irq;
      logic hs_drive;
      logic lsa_drive;
      logic lsb_drive;
      logic irq_n;
      logic [3:0] rdata;
   } lsc_state_s;

   lsc_state_s st;
   lsc_state_s next_st;
   lsc_pins_s pins_raw;
   lsc_pins_s p;
   lsc_req_s req;

   // Assertions below all run on the one system clock
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RSTN_I);

   // ==========================================================
   // Pin synchronisation
   always_comb begin
      pins_raw.pulse = DIRECT_PULSE_INPUT_I;
      pins_raw.high_voltage = HIGH_VOLTAGE_I;
      pins_raw.hs_overtemp = HS_OVERTEMP_I;
      pins_raw.hs_open_load = HS_OPEN_LOAD_I;
      pins_raw.hs_current_limit = HS_CURRENT_LIMIT_I;
      pins_raw.ls_overtemp = LS_OVERTEMP_I;
      pins_raw.lsa_open_load = LS_A_OPEN_LOAD_I;
      pins_raw.lsa_current_limit = LS_A_CURRENT_LIMIT_I;
      pins_raw.lsb_open_load = LS_B_OPEN_LOAD_I;
      pins_raw.lsb_current_limit = LS_B_CURRENT_LIMIT_I;
      req.addr = ADDR_I;
      req.wdata = WDATA_I;
      req.wr = WR_I;
      req.rd = RD_I;
   end

   lsc_sync #(
      .W($bits(lsc_pins_s))
   ) u_sync (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .d_i(pins_raw),
      .q_o(p)
   );

   // ==========================================================
   // Decode and conditions
   logic wr_mode_ctl;
   logic wr_high_ctl;
   logic wr_low_ctl;
   logic wr_irq_mask;
   logic rd_irq_source;
   logic hv_cond;
   logic hs_ot_rise;
   logic ls_ot_rise;
   logic [1:0] ls_ctl_on;
   logic [1:0] ls_ctl_pen;
   logic [1:0] ls_gate;

   assign wr_mode_ctl = req.wr && (req.addr == LSC_MODE_CONTROL_REG);
   assign wr_high_ctl = req.wr && (req.addr == LSC_HIGH_SWITCH_CONTROL_REG);
   assign wr_low_ctl = req.wr && (req.addr == LSC_LOW_SWITCH_CONTROL_REG);
   assign wr_irq_mask = req.wr && (req.addr == LSC_INTERRUPT_MASK_REG);
   assign rd_irq_source = req.rd && (req.addr == LSC_INTERRUPT_SOURCE_REG);
   // Supply condition only counts while shutdown on overvoltage is enabled
   assign hv_cond = p.high_voltage && st.overvoltage_shutdown_enable; // R8 R20
   assign hs_ot_rise = p.hs_overtemp && !st.hs_ot_prev;
   assign ls_ot_rise = p.ls_overtemp && !st.ls_ot_prev;

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      next_st.hs_ot_prev = p.hs_overtemp;
      next_st.ls_ot_prev = p.ls_overtemp;

      if (wr_mode_ctl) begin
         next_st.overvoltage_shutdown_enable = req.wdata[LSC_OV_SHUT_EN_BIT];
      end
      if (wr_irq_mask) begin
         next_st.high_switch_irq_mask = req.wdata[LSC_HIGH_MASK_BIT];
         next_st.low_switch_irq_mask = req.wdata[LSC_LOW_MASK_BIT];
      end
      if (wr_high_ctl) begin
         next_st.high_switch_pulse_enable = req.wdata[LSC_HS_PEN_BIT];
         next_st.high_switch_on = req.wdata[LSC_HS_ON_BIT];
      end
      if (wr_low_ctl) begin
         next_st.low_switch_b_pulse_enable = req.wdata[LSC_LSB_PEN_BIT];
         next_st.low_switch_a_pulse_enable = req.wdata[LSC_LSA_PEN_BIT];
         next_st.low_switch_b_on = req.wdata[LSC_LSB_ON_BIT];
         next_st.low_switch_a_on = req.wdata[LSC_LSA_ON_BIT];
      end

      // Shutdown latches: a live condition always wins over the releasing write
      if (wr_high_ctl && !p.hs_overtemp) begin
         next_st.hs_ot_shut = 1'b0; // R7
      end
      if (p.hs_overtemp) begin
         next_st.hs_ot_shut = 1'b1; // R4
      end
      if (wr_high_ctl && !hv_cond) begin
         next_st.hs_hv_shut = 1'b0; // R9
      end
      if (hv_cond) begin
         next_st.hs_hv_shut = 1'b1; // R8
      end
      if (wr_low_ctl && !p.ls_overtemp) begin
         next_st.ls_ot_shut = 1'b0; // R19
      end
      if (p.ls_overtemp) begin
         next_st.ls_ot_shut = 1'b1; // R15
      end
      if (wr_low_ctl && !hv_cond) begin
         next_st.ls_hv_shut = 1'b0; // R21
      end
      if (hv_cond) begin
         next_st.ls_hv_shut = 1'b1; // R20
      end

      // Interrupt source latches, each read of the source register clears only the one it reports
      if (rd_irq_source) begin
         if (st.hs_irq) begin
            next_st.hs_irq = 1'b0;
         end else begin
            next_st.ls_irq = 1'b0;
         end
      end
      if (hs_ot_rise && st.high_switch_irq_mask) begin
         next_st.hs_irq = 1'b1; // R4 R6 R18
      end
      if (ls_ot_rise && st.low_switch_irq_mask) begin
         next_st.ls_irq = 1'b1; // R15 R17 R18
      end
      next_st.irq_n = !(next_st.hs_irq || next_st.ls_irq); // R6 R17 R18

      // Switch drive, computed from the updated latches so shutdown acts at once
      next_st.hs_drive = next_st.high_switch_on
         && (!next_st.high_switch_pulse_enable || p.pulse) // R1 R23
         && !next_st.hs_ot_shut && !next_st.hs_hv_shut; // R24 R10
      ls_ctl_on = {next_st.low_switch_b_on, next_st.low_switch_a_on};
      ls_ctl_pen = {next_st.low_switch_b_pulse_enable, next_st.low_switch_a_pulse_enable};
      for (int i = 0; i < 2; i++) begin
         ls_gate[i] = ls_ctl_on[i] && (!ls_ctl_pen[i] || p.pulse); // R11 R12 R23
      end
      next_st.lsa_drive = ls_gate[0] && !next_st.ls_ot_shut && !next_st.ls_hv_shut
         && !LOW_POWER_I; // R22 R24
      next_st.lsb_drive = ls_gate[1] && !next_st.ls_ot_shut && !next_st.ls_hv_shut
         && !LOW_POWER_I; // R22 R24

      // Read data stands for one cycle only
      next_st.rdata = LSC_ZERO4;
      if (req.rd) begin
         unique case (req.addr)
            LSC_HIGH_SWITCH_CONTROL_REG, LSC_HIGH_SWITCH_STATUS_REG: begin
               if (st.hs_ot_shut) begin
                  next_st.rdata[LSC_HS_OL_BIT] = 1'b1; // R5
                  next_st.rdata[LSC_HS_CL_BIT] = 1'b1; // R5
               end else begin
                  next_st.rdata[LSC_HS_OL_BIT] = p.hs_open_load; // R2
                  next_st.rdata[LSC_HS_CL_BIT] = p.hs_current_limit; // R3
               end
            end
            LSC_LOW_SWITCH_CONTROL_REG, LSC_LOW_SWITCH_STATUS_REG: begin
               if (st.ls_ot_shut) begin
                  next_st.rdata = LSC_ALL_FLAGS; // R16
               end else begin
                  next_st.rdata[LSC_LSB_OL_BIT] = p.lsb_open_load; // R13
                  next_st.rdata[LSC_LSB_CL_BIT] = p.lsb_current_limit; // R14
                  next_st.rdata[LSC_LSA_OL_BIT] = p.lsa_open_load; // R13
                  next_st.rdata[LSC_LSA_CL_BIT] = p.lsa_current_limit; // R14
               end
            end
            LSC_INTERRUPT_MASK_REG: begin
               next_st.rdata[LSC_HIGH_MASK_BIT] = st.high_switch_irq_mask;
               next_st.rdata[LSC_LOW_MASK_BIT] = st.low_switch_irq_mask;
            end
            LSC_INTERRUPT_SOURCE_REG: begin
               // High side reported first when both are pending
               if (st.hs_irq) begin
                  next_st.rdata = LSC_SRC_HIGH; // R4
               end else if (st.ls_irq) begin
                  next_st.rdata = LSC_SRC_LOW; // R15
               end else begin
                  next_st.rdata = LSC_SRC_NONE;
               end
            end
            default: begin
               next_st.rdata = LSC_ZERO4;
            end
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st <= '0;
         st.irq_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign RDATA_O = st.rdata;
   assign HIGH_SWITCH_ON_O = st.hs_drive;
   assign LOW_SWITCH_A_ON_O = st.lsa_drive;
   assign LOW_SWITCH_B_ON_O = st.lsb_drive;
   assign IRQ_N_O = st.irq_n;

   // ==========================================================
   // Assertions

   property p_hs_ot_off;
      p.hs_overtemp |=> !st.hs_drive ##1 !st.hs_drive;
   endproperty
   a_hs_ot_off: assert property (p_hs_ot_off) else $error("high switch on in overtemp"); // R4

   property p_hs_flags;
      st.hs_ot_shut && req.rd && (req.addr == LSC_HIGH_SWITCH_STATUS_REG)
         |=> RDATA_O[1:0] == LSC_BOTH2;
   endproperty
   a_hs_flags: assert property (p_hs_flags) else $error("thermal flags not both set"); // R5

   property p_hs_irq;
      hs_ot_rise && st.high_switch_irq_mask |=> !IRQ_N_O;
   endproperty
   a_hs_irq: assert property (p_hs_irq) else $error("no irq on high overtemp"); // R6

   property p_ls_irq;
      ls_ot_rise && st.low_switch_irq_mask && !st.hs_irq |=> !IRQ_N_O && st.ls_irq;
   endproperty
   a_ls_irq: assert property (p_ls_irq) else $error("no irq on low overtemp"); // R17

   property p_masked;
      !st.high_switch_irq_mask && !st.low_switch_irq_mask && !st.hs_irq && !st.ls_irq
         |=> IRQ_N_O;
   endproperty
   a_masked: assert property (p_masked) else $error("masked source raised irq"); // R18

   property p_hs_hold;
      st.hs_ot_shut && !wr_high_ctl |=> st.hs_ot_shut && !HIGH_SWITCH_ON_O;
   endproperty
   a_hs_hold: assert property (p_hs_hold) else $error("high switch left shutdown"); // R24

   property p_hs_release;
      st.hs_ot_shut && !st.hs_hv_shut && wr_high_ctl && !p.hs_overtemp && !hv_cond
         |=> !st.hs_ot_shut;
   endproperty
   a_hs_release: assert property (p_hs_release) else $error("high re-enable failed"); // R7

   property p_hv_off;
      hv_cond |=> !HIGH_SWITCH_ON_O && !LOW_SWITCH_A_ON_O && !LOW_SWITCH_B_ON_O;
   endproperty
   a_hv_off: assert property (p_hv_off) else $error("switch on in overvoltage"); // R8

   property p_ls_ot_off;
      p.ls_overtemp |=> !LOW_SWITCH_A_ON_O && !LOW_SWITCH_B_ON_O;
   endproperty
   a_ls_ot_off: assert property (p_ls_ot_off) else $error("low switch on in overtemp"); // R15

   property p_low_power;
      LOW_POWER_I |=> !LOW_SWITCH_A_ON_O && !LOW_SWITCH_B_ON_O;
   endproperty
   a_low_power: assert property (p_low_power) else $error("low switch on in low power"); // R22

   property p_hs_pulse;
      st.high_switch_on && st.high_switch_pulse_enable && !st.hs_ot_shut && !st.hs_hv_shut
         && !p.hs_overtemp && !hv_cond && !req.wr |=> HIGH_SWITCH_ON_O == $past(p.pulse);
   endproperty
   a_hs_pulse: assert property (p_hs_pulse) else $error("high pulse gating wrong"); // R1

   property p_lsa_plain;
      st.low_switch_a_on && !st.low_switch_a_pulse_enable && !st.ls_ot_shut
         && !st.ls_hv_shut && !p.ls_overtemp && !hv_cond && !LOW_POWER_I && !req.wr
         |=> LOW_SWITCH_A_ON_O;
   endproperty
   a_lsa_plain: assert property (p_lsa_plain) else $error("low switch a not on"); // R23

   property p_rd_once;
      !req.rd |=> RDATA_O == LSC_ZERO4;
   endproperty
   a_rd_once: assert property (p_rd_once) else $error("read data held too long");

   property p_ls_flags;
      st.ls_ot_shut && req.rd && (req.addr == LSC_LOW_SWITCH_STATUS_REG)
         |=> RDATA_O == LSC_ALL_FLAGS;
   endproperty
   a_ls_flags: assert property (p_ls_flags) else $error("low flags not all set"); // R16

   property p_ls_release;
      st.ls_ot_shut && wr_low_ctl && !p.ls_overtemp |=> !st.ls_ot_shut;
   endproperty
   a_ls_release: assert property (p_ls_release) else $error("low re-enable failed"); // R19

   c_hs_shut_release: cover property (st.hs_ot_shut ##1 !st.hs_ot_shut);
   c_ls_shut_release: cover property (st.ls_ot_shut ##1 !st.ls_ot_shut);
   c_ls_irq_read: cover property (st.ls_irq && rd_irq_source ##1 IRQ_N_O);
   c_hs_pulsing: cover property (HIGH_SWITCH_ON_O ##1 !HIGH_SWITCH_ON_O ##1 HIGH_SWITCH_ON_O);
   c_hv_shut: cover property (st.ls_hv_shut && st.hs_hv_shut);

endmodule
`default_nettype wire

// File: test/lsc_load_model.sv
// Behavioural loads on the three switch outputs: open and short per output
`timescale 1ns/1ps
`default_nettype none
module lsc_load_model (
   input wire logic [2:0] on_i,
   input wire logic [2:0] open_i,
   input wire logic [2:0] short_i,
   output logic [2:0] open_load_o,
   output logic [2:0] current_limit_o
);
   // ==========================================================
   // Comparator levels
   // An off switch carries no current, so it reads as open load too
   assign open_load_o = ~on_i | open_i;
   // Limitation only while driven into a short
   assign current_limit_o = on_i & short_i & ~open_i;
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the load switch control block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import lsc_pkg::*;
;
   typedef struct packed {
      logic [3:0] hs;
      logic [3:0] ls;
      logic pulse;
      logic [2:0] sw;
   } lsc_row_s;
   // Switch pattern is {high, low a, low b}
   localparam lsc_row_s ROWS [0:8] = '{
      '{4'h1, 4'h0, 1'b0, 3'h4}, '{4'h5, 4'h0, 1'b0, 3'h0}, '{4'h5, 4'h0, 1'b1, 3'h4},
      '{4'h1, 4'h3, 1'b0, 3'h7}, '{4'h0, 4'h2, 1'b0, 3'h1}, '{4'h0, 4'h7, 1'b0, 3'h1},
      '{4'h0, 4'hB, 1'b0, 3'h2}, '{4'h5, 4'hF, 1'b1, 3'h7}, '{4'h4, 4'hC, 1'b1, 3'h0}};
   logic clk, rstn, wr, rd, low_power, pulse, high_voltage, hs_ot, ls_ot;
   logic [3:0] addr, wdata, rdata;
   logic hs_on, lsa_on, lsb_on, irq_n;
   logic [2:0] ld_open, ld_short, open_load, current_limit;
   int failures;
   int cmp_count;

   // ==========================================================
   // Design and loads
   lsc_top lsc_top_inst (
      .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .LOW_POWER_I(low_power), .DIRECT_PULSE_INPUT_I(pulse),
      .HIGH_VOLTAGE_I(high_voltage), .HS_OVERTEMP_I(hs_ot),
      .HS_OPEN_LOAD_I(open_load[2]), .HS_CURRENT_LIMIT_I(current_limit[2]),
      .LS_OVERTEMP_I(ls_ot), .LS_A_OPEN_LOAD_I(open_load[1]),
      .LS_A_CURRENT_LIMIT_I(current_limit[1]), .LS_B_OPEN_LOAD_I(open_load[0]),
      .LS_B_CURRENT_LIMIT_I(current_limit[0]), .HIGH_SWITCH_ON_O(hs_on),
      .LOW_SWITCH_A_ON_O(lsa_on), .LOW_SWITCH_B_ON_O(lsb_on), .IRQ_N_O(irq_n));
   lsc_load_model lsc_load_model_inst (
      .on_i({hs_on, lsa_on, lsb_on}), .open_i(ld_open), .short_i(ld_short),
      .open_load_o(open_load), .current_limit_o(current_limit));

   // ==========================================================
   // Bus and compare tasks
   task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [3:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp_count++;
      if (rdata !== exp) begin
         failures++;
         $display("BAD t=%0t rd got=%h exp=%h", $time, rdata, exp);
      end
      // Hand back on an edge so the next stimulus lands on it
      @(posedge clk);
   endtask
   // Outputs as {high, low a, low b, irq_n}
   task automatic chk_out(input logic [3:0] exp);
      #1;
      cmp_count++;
      if ({hs_on, lsa_on, lsb_on, irq_n} !== exp) begin
         failures++;
         $display("BAD t=%0t out got=%h exp=%h", $time, {hs_on, lsa_on, lsb_on, irq_n}, exp);
      end
      @(posedge clk);
   endtask
   // Two synchroniser edges plus the output register, one edge of margin
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      results();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rstn, wr, rd, low_power, pulse, high_voltage, hs_ot, ls_ot} = 8'h00;
      addr = 4'h0;
      wdata = 4'h0;
      ld_open = 3'h0;
      ld_short = 3'h0;
      failures = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      chk_out(4'h1);
      chk_rd(LSC_INTERRUPT_MASK_REG, 4'h0);
      chk_rd(LSC_INTERRUPT_SOURCE_REG, 4'h0);
      chk_rd(4'h3, 4'h0);
      foreach (ROWS[i]) begin
         pulse <= ROWS[i].pulse;
         wr_reg(LSC_HIGH_SWITCH_CONTROL_REG, ROWS[i].hs);
         wr_reg(LSC_LOW_SWITCH_CONTROL_REG, ROWS[i].ls);
         settle();
         chk_out({ROWS[i].sw, 1'b1});
      end
      // Status flags follow the loads
      wr_reg(LSC_HIGH_SWITCH_CONTROL_REG, 4'h1);
      wr_reg(LSC_LOW_SWITCH_CONTROL_REG, 4'h3);
      ld_open <= 3'b101;
      ld_short <= 3'b010;
      settle();
      chk_rd(LSC_HIGH_SWITCH_STATUS_REG, 4'h2);
      chk_rd(LSC_LOW_SWITCH_STATUS_REG, 4'h9);
      ld_open <= 3'b000;
      ld_short <= 3'b100;
      settle();
      chk_rd(LSC_HIGH_SWITCH_CONTROL_REG, 4'h1);
      ld_short <= 3'b000;
      wr_reg(LSC_HIGH_SWITCH_STATUS_REG, 4'hF);
      settle();
      chk_rd(LSC_HIGH_SWITCH_STATUS_REG, 4'h0);
      wr_reg(LSC_LOW_SWITCH_CONTROL_REG, 4'h0);
      settle();
      chk_rd(LSC_LOW_SWITCH_STATUS_REG, 4'hA);
      wr_reg(LSC_LOW_SWITCH_CONTROL_REG, 4'h3);
      // Masked high overtemperature: shut down, no source, no request
      @(posedge clk);
      hs_ot <= 1'b1;
      settle();
      chk_out(4'h7);
      chk_rd(LSC_HIGH_SWITCH_STATUS_REG, 4'h3);
      chk_rd(LSC_INTERRUPT_SOURCE_REG, 4'h0);
      hs_ot <= 1'b0;
      settle();
      chk_out(4'h7);
      wr_reg(LSC_HIGH_SWITCH_CONTROL_REG, 4'h1);
      chk_out(4'hF);
      // Unmasked events on both sides
      wr_reg(LSC_INTERRUPT_MASK_REG, 4'h3);
      chk_rd(LSC_INTERRUPT_MASK_REG, 4'h3);
      hs_ot <= 1'b1;
      settle();
      chk_out(4'h6);
      wr_reg(LSC_HIGH_SWITCH_CONTROL_REG, 4'h1);
      chk_out(4'h6);
      hs_ot <= 1'b0;
      settle();
      chk_out(4'h6);
      wr_reg(LSC_HIGH_SWITCH_CONTROL_REG, 4'h1);
      chk_out(4'hE);
      ls_ot <= 1'b1;
      settle();
      chk_out(4'h8);
      chk_rd(LSC_LOW_SWITCH_STATUS_REG, 4'hF);
      chk_rd(LSC_INTERRUPT_SOURCE_REG, LSC_SRC_HIGH);
      chk_out(4'h8);
      chk_rd(LSC_INTERRUPT_SOURCE_REG, LSC_SRC_LOW);
      chk_out(4'h9);
      chk_rd(LSC_INTERRUPT_SOURCE_REG, LSC_SRC_NONE);
      ls_ot <= 1'b0;
      settle();
      chk_out(4'h9);
      wr_reg(LSC_LOW_SWITCH_CONTROL_REG, 4'h3);
      chk_out(4'hF);
      // High supply voltage, first with the shutdown disabled
      high_voltage <= 1'b1;
      settle();
      chk_out(4'hF);
      wr_reg(LSC_MODE_CONTROL_REG, 4'h8);
      settle();
      chk_out(4'h1);
      high_voltage <= 1'b0;
      settle();
      chk_out(4'h1);
      wr_reg(LSC_HIGH_SWITCH_CONTROL_REG, 4'h1);
      chk_out(4'h9);
      wr_reg(LSC_LOW_SWITCH_CONTROL_REG, 4'h3);
      chk_out(4'hF);
      wr_reg(LSC_MODE_CONTROL_REG, 4'h0);
      // Low power keeps only the high switch
      low_power <= 1'b1;
      repeat (2) @(posedge clk);
      chk_out(4'h9);
      low_power <= 1'b0;
      repeat (2) @(posedge clk);
      chk_out(4'hF);
      // Reset in mid-run with a request pending must drop everything
      hs_ot <= 1'b1;
      settle();
      chk_out(4'h6);
      rstn <= 1'b0;
      @(posedge clk);
      chk_out(4'h1);
      hs_ot <= 1'b0;
      rstn <= 1'b1;
      chk_out(4'h1);
      chk_rd(LSC_INTERRUPT_MASK_REG, 4'h0);
      chk_rd(LSC_INTERRUPT_SOURCE_REG, LSC_SRC_NONE);
      results();
   end
endmodule
`default_nettype wire
